// *** dv/pifb_src_model.sv ***
/* Event source model: turns one-cycle requests into event strobes.
   Assumes requests change just after a rising edge. */
`timescale 1ns/100ps
module pifb_src_model (
	input wire logic ref_clk,
	input wire logic [7:0] cc_req,
	input wire logic [4:0] tc_req,
	output logic [7:0] capcmp_event,
	output pifb_pkg::pifb_tc_events_t tc_events
);
	import pifb_pkg::*;
	// Registered so strobes start on an edge, like real timer logic
	always_ff @(posedge ref_clk) begin
		capcmp_event <= cc_req;
		tc_events <= tc_req;
	end
endmodule

// *** dv/pifb_sva.sv ***
/* Port checker for pifb_bank.
   Assumes it is bound to every pifb_bank instance. */
`timescale 1ns/100ps
`include "pifb_params.svh"
module pifb_sva #(parameter int NUM_CAPCMP = 8) (
	input wire logic ref_clk,
	input wire logic reset,
	input pifb_pkg::pifb_bus_req_t bus_req,
	input wire logic [`PIFB_DATA_W-1:0] bus_rdata,
	input wire logic [NUM_CAPCMP-1:0] capcmp_event,
	input wire logic [NUM_CAPCMP-1:0] capcmp_pwm_mode,
	input pifb_pkg::pifb_tc_events_t tc_events,
	input pifb_pkg::pifb_ext_flags_t ext_flags,
	input wire logic global_peripheral_irq_enable,
	input wire logic priority_levels_enable,
	input wire logic periph_irq_pending,
	input wire logic periph_irq_req
);
	import pifb_pkg::*;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	wire gate_ok = priority_levels_enable || global_peripheral_irq_enable;
	wire rd_tcf = bus_req.rd && bus_req.addr == `PIFB_OFF_TC_FLAG;
	wire rd_tce = bus_req.rd && bus_req.addr == `PIFB_OFF_TC_EN;
	wire rd_ccf = bus_req.rd && bus_req.addr == `PIFB_OFF_CCP_FLAG;
	a_req_gate: assert property (periph_irq_req == (periph_irq_pending && gate_ok)) else $error("bad gating");
	a_pend_hold: assert property (periph_irq_pending && !bus_req.wr ##1 $stable(ext_flags) |-> periph_irq_pending)
		else $error("pending dropped");
	a_tcf_top: assert property (rd_tcf |=> bus_rdata[7:6] == 2'h0) else $error("flag top bits");
	a_tce_top: assert property (rd_tce |=> bus_rdata[7:6] == 2'h0) else $error("enable top bits");
	a_rd_once: assert property (!$past(bus_req.rd) |-> bus_rdata == 8'h00) else $error("stray read data");
	a_rst_clear: assert property ($fell(reset) |-> bus_rdata == 8'h00 && !periph_irq_pending) else $error("reset");
	a_tc_sets: assert property (tc_events.timer1_gate ##1 rd_tcf |=> bus_rdata[0]) else $error("gate flag");
	a_cc_sets: assert property (capcmp_event[0] && !capcmp_pwm_mode[0] ##1 rd_ccf |=> bus_rdata[0])
		else $error("module flag");
	c_req: cover property (periph_irq_req);
	c_pend: cover property ($rose(periph_irq_pending));
	c_pwm: cover property (capcmp_event[7] && capcmp_pwm_mode[7]);
endmodule
bind pifb_bank pifb_sva #(.NUM_CAPCMP(NUM_CAPCMP)) sva_u (.ref_clk, .reset, .bus_req, .bus_rdata, .capcmp_event,
	.capcmp_pwm_mode, .tc_events, .ext_flags, .global_peripheral_irq_enable, .priority_levels_enable,
	.periph_irq_pending, .periph_irq_req);

// *** dv/tb_top.sv ***
/* Bench for pifb_bank: register tasks, event source model, checks.
   Assumes the bound checker; runs the full and the small package variant side by side. */
`timescale 1ns/100ps
`include "pifb_params.svh"
module tb_top;
	import pifb_pkg::*;
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	pifb_bus_req_t bus_req = '0;
	logic [7:0] bus_rdata, capcmp_event, capcmp_pwm_mode = 8'h00, cc_req = 8'h00;
	logic [4:0] tc_req = 5'h00;
	pifb_tc_events_t tc_events;
	pifb_ext_flags_t ext_flags = '0;
	logic comparator3_out = 1'b0;
	logic global_peripheral_irq_enable = 1'b0;
	logic priority_levels_enable = 1'b0;
	logic periph_irq_pending, periph_irq_req;
	logic [7:0] rdata_small;
	logic pending_small, req_small;
	int num_errors = 0, cmp_count = 0, cyc = 0;
	logic [11:0] regs [7] = '{`PIFB_OFF_CCP_EN, `PIFB_OFF_CCP_FLAG, `PIFB_OFF_TC_EN, `PIFB_OFF_TC_FLAG,
		`PIFB_OFF_EN_FIRST, `PIFB_OFF_EN_SECOND, `PIFB_OFF_EN_THIRD};
	// Comparator flag only clears, so writing ones leaves it low
	logic [7:0] full [7] = '{8'hFF, 8'hFF, 8'h3F, 8'h1F, 8'hFF, 8'hFF, 8'hFF};
	pifb_src_model src_u (.ref_clk, .cc_req, .tc_req, .capcmp_event, .tc_events);
	pifb_bank dut_u (.ref_clk, .reset, .bus_req, .bus_rdata, .capcmp_event, .capcmp_pwm_mode, .comparator3_out,
		.tc_events, .ext_flags, .global_peripheral_irq_enable, .priority_levels_enable, .periph_irq_pending,
		.periph_irq_req);
	pifb_bank #(.SMALL_PACKAGE(1'b1)) dut_small_u (.ref_clk, .reset, .bus_req, .bus_rdata(rdata_small), .capcmp_event,
		.capcmp_pwm_mode, .comparator3_out, .tc_events, .ext_flags, .global_peripheral_irq_enable,
		.priority_levels_enable, .periph_irq_pending(pending_small), .periph_irq_req(req_small));
	initial begin
		forever #50 ref_clk = ~ref_clk;
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic pq(input logic [1:0] e);
		chk({6'h00, periph_irq_pending, periph_irq_req}, {6'h00, e});
	endtask
	task automatic w(input logic [11:0] a, input logic [7:0] d);
		@(posedge ref_clk) bus_req <= '{a, d, 1'b1, 1'b0};
		@(posedge ref_clk) bus_req <= '0;
		#1;
	endtask
	task automatic r(input logic [11:0] a, input logic [7:0] e);
		@(posedge ref_clk) bus_req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge ref_clk) bus_req <= '0;
		#1 chk(bus_rdata, e);
		chk(rdata_small, (a == `PIFB_OFF_EN_FIRST) ? (e & 8'h7F) : e);
	endtask
	task automatic fire(input logic [7:0] c, input logic [4:0] t);
		@(posedge ref_clk) begin
			cc_req <= c;
			tc_req <= t;
		end
		@(posedge ref_clk) begin
			cc_req <= 8'h00;
			tc_req <= 5'h00;
		end
	endtask
	task automatic summarize;
		if (num_errors == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 1000) begin
			num_errors++;
			summarize();
		end
	end
	initial begin
		repeat (10) @(posedge ref_clk);
		reset <= 1'b0;
		foreach (regs[i]) r(regs[i], 8'h00);
		foreach (regs[i]) w(regs[i], 8'hFF);
		foreach (regs[i]) r(regs[i], full[i]);
		w(12'hF90, 8'hFF);
		r(12'hF90, 8'h00);
		foreach (regs[i]) w(regs[i], 8'h00);
		fire(8'hFF, 5'h1F);
		r(`PIFB_OFF_TC_FLAG, 8'h1F);
		r(`PIFB_OFF_CCP_FLAG, 8'hFF);
		pq(2'h0);
		@(posedge ref_clk) capcmp_pwm_mode <= 8'hF0;
		w(`PIFB_OFF_CCP_FLAG, 8'h00);
		fire(8'hFF, 5'h00);
		r(`PIFB_OFF_CCP_FLAG, 8'h0F);
		w(`PIFB_OFF_CCP_EN, 8'hF0);
		pq(2'h0);
		w(`PIFB_OFF_CCP_EN, 8'h01);
		pq(2'h2);
		w(`PIFB_OFF_CCP_FLAG, 8'h00);
		pq(2'h0);
		fire(8'h00, 5'h01);
		w(`PIFB_OFF_TC_EN, 8'h01);
		pq(2'h2);
		@(posedge ref_clk) global_peripheral_irq_enable <= 1'b1;
		#1 pq(2'h3);
		@(posedge ref_clk) begin
			global_peripheral_irq_enable <= 1'b0;
			priority_levels_enable <= 1'b1;
		end
		#1 pq(2'h3);
		w(`PIFB_OFF_TC_FLAG, 8'h00);
		@(posedge ref_clk) comparator3_out <= 1'b1;
		repeat (4) @(posedge ref_clk);
		r(`PIFB_OFF_TC_FLAG, 8'h20);
		w(`PIFB_OFF_TC_FLAG, 8'h00);
		r(`PIFB_OFF_TC_FLAG, 8'h00);
		@(posedge ref_clk) ext_flags.first <= 8'h80;
		w(`PIFB_OFF_EN_FIRST, 8'h80);
		pq(2'h3);
		chk({6'h00, pending_small, req_small}, 8'h00);
		@(posedge ref_clk) begin
			ext_flags.first <= 8'h00;
			ext_flags.second <= 8'h40;
			ext_flags.third <= 8'h02;
		end
		#1 pq(2'h0);
		w(`PIFB_OFF_EN_SECOND, 8'h40);
		pq(2'h3);
		w(`PIFB_OFF_EN_SECOND, 8'h00);
		w(`PIFB_OFF_EN_THIRD, 8'h02);
		pq(2'h3);
		summarize();
	end
endmodule

// *** src/pifb_bank.sv ***
/*
  Peripheral interrupt flag registers 4 and 5 and enable registers 1 to 5,
  with the combined peripheral interrupt request toward the core.
  Assumes: register port on ref_clk with read data one cycle after the read
  strobe; event strobes and external flags from logic on ref_clk; the
  comparator three output arrives from the analog side and is synchronised.
*/
// Added by the designer: the address-and-strobe port.
`timescale 1ns/100ps
`include "pifb_params.svh"

module pifb_bank #(
	parameter bit SMALL_PACKAGE = 1'b0,
	parameter int NUM_CAPCMP = 8
) (
	input wire logic ref_clk,
	input wire logic reset,
	input pifb_pkg::pifb_bus_req_t bus_req,
	output logic [`PIFB_DATA_W-1:0] bus_rdata,
	input wire logic [NUM_CAPCMP-1:0] capcmp_event,
	input wire logic [NUM_CAPCMP-1:0] capcmp_pwm_mode,
	input wire logic comparator3_out,
	input pifb_pkg::pifb_tc_events_t tc_events,
	input pifb_pkg::pifb_ext_flags_t ext_flags,
	input wire logic global_peripheral_irq_enable,
	input wire logic priority_levels_enable,
	output logic periph_irq_pending,
	output logic periph_irq_req
);
	import pifb_pkg::*;

	function automatic logic hit(input logic [`PIFB_ADDR_W-1:0] a, input logic [`PIFB_ADDR_W-1:0] off);
		hit = (a == off);
	endfunction

	logic [`PIFB_DATA_W-1:0] ccp_group_irq_flags_q, ccp_group_irq_flags_d;
	logic [`PIFB_DATA_W-1:0] ccp_group_irq_enable_q, ccp_group_irq_enable_d;
	logic [`PIFB_DATA_W-1:0] timer_comp_irq_flags_q, timer_comp_irq_flags_d;
	logic [`PIFB_DATA_W-1:0] timer_comp_irq_enable_q, timer_comp_irq_enable_d;
	logic [`PIFB_DATA_W-1:0] periph_irq_enable_first_q, periph_irq_enable_first_d;
	logic [`PIFB_DATA_W-1:0] periph_irq_enable_second_q, periph_irq_enable_second_d;
	logic [`PIFB_DATA_W-1:0] periph_irq_enable_third_q, periph_irq_enable_third_d;
	logic [`PIFB_DATA_W-1:0] rdata_q, rdata_d;
	logic cmp3_meta_q, cmp3_sync_q, cmp3_prev_q;
	logic [2:0] cmp3_fill_q;
	logic [`PIFB_DATA_W-1:0] ccp_set, tc_set, first_mask;
	logic cmp3_change;

	// Analog output: two stages before the edge detector looks at it
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			cmp3_meta_q <= 1'b0;
			cmp3_sync_q <= 1'b0;
			cmp3_prev_q <= 1'b0;
			cmp3_fill_q <= 3'h0;
		end else begin
			cmp3_meta_q <= comparator3_out;
			cmp3_sync_q <= cmp3_meta_q;
			cmp3_prev_q <= cmp3_sync_q;
			cmp3_fill_q <= {cmp3_fill_q[1:0], 1'b1};
		end
	end
	// Armed only once the pipeline holds the pin's level, so a comparator idling high
	// gives no false change after reset; a change in those first cycles is not flagged
	assign cmp3_change = (cmp3_sync_q ^ cmp3_prev_q) & cmp3_fill_q[2];

	// Event sources; capture and compare share one strobe per module
	generate
		for (genvar i = 0; i < NUM_CAPCMP; i++) begin : g_ccp
			assign ccp_set[i] = capcmp_event[i] & ~capcmp_pwm_mode[i];
		end
	endgenerate
	assign tc_set = {2'b00, cmp3_change, tc_events.timer8_period_match,
		tc_events.timer6_period_match, tc_events.timer5_overflow,
		tc_events.timer5_gate, tc_events.timer1_gate};

	// The small package has no parallel port, so its enable stays at zero
	assign first_mask = SMALL_PACKAGE ? ~(8'h01 << `PIFB_BIT_PARPORT) : 8'hFF;

	always_comb begin
		logic wr;
		wr = bus_req.wr;
		// Hardware set is ORed after the write so an event never loses to a clear
		ccp_group_irq_flags_d = ccp_group_irq_flags_q;
		if (wr && hit(bus_req.addr, `PIFB_OFF_CCP_FLAG)) begin
			ccp_group_irq_flags_d = bus_req.wdata;
		end
		ccp_group_irq_flags_d = ccp_group_irq_flags_d | ccp_set;
		timer_comp_irq_flags_d = timer_comp_irq_flags_q;
		if (wr && hit(bus_req.addr, `PIFB_OFF_TC_FLAG)) begin
			// Comparator bit may only be cleared by software, never set
			timer_comp_irq_flags_d = bus_req.wdata & `PIFB_TC_IMPL_MASK;
			timer_comp_irq_flags_d[`PIFB_BIT_CMP3] = bus_req.wdata[`PIFB_BIT_CMP3]
				& timer_comp_irq_flags_q[`PIFB_BIT_CMP3];
		end
		timer_comp_irq_flags_d = timer_comp_irq_flags_d | tc_set;
		ccp_group_irq_enable_d = ccp_group_irq_enable_q;
		if (wr && hit(bus_req.addr, `PIFB_OFF_CCP_EN)) begin
			ccp_group_irq_enable_d = bus_req.wdata;
		end
		timer_comp_irq_enable_d = timer_comp_irq_enable_q;
		if (wr && hit(bus_req.addr, `PIFB_OFF_TC_EN)) begin
			timer_comp_irq_enable_d = bus_req.wdata & `PIFB_TC_IMPL_MASK;
		end
		periph_irq_enable_first_d = periph_irq_enable_first_q;
		if (wr && hit(bus_req.addr, `PIFB_OFF_EN_FIRST)) begin
			periph_irq_enable_first_d = bus_req.wdata & first_mask;
		end
		periph_irq_enable_second_d = periph_irq_enable_second_q;
		if (wr && hit(bus_req.addr, `PIFB_OFF_EN_SECOND)) begin
			periph_irq_enable_second_d = bus_req.wdata;
		end
		periph_irq_enable_third_d = periph_irq_enable_third_q;
		if (wr && hit(bus_req.addr, `PIFB_OFF_EN_THIRD)) begin
			periph_irq_enable_third_d = bus_req.wdata;
		end
		// Read answer; unmapped addresses and idle cycles return zero
		rdata_d = `PIFB_RESET_BYTE;
		if (bus_req.rd) begin
			case (bus_req.addr)
				`PIFB_OFF_CCP_FLAG: rdata_d = ccp_group_irq_flags_q;
				`PIFB_OFF_CCP_EN: rdata_d = ccp_group_irq_enable_q;
				`PIFB_OFF_TC_FLAG: rdata_d = timer_comp_irq_flags_q & `PIFB_TC_IMPL_MASK;
				`PIFB_OFF_TC_EN: rdata_d = timer_comp_irq_enable_q & `PIFB_TC_IMPL_MASK;
				`PIFB_OFF_EN_FIRST: rdata_d = periph_irq_enable_first_q;
				`PIFB_OFF_EN_SECOND: rdata_d = periph_irq_enable_second_q;
				`PIFB_OFF_EN_THIRD: rdata_d = periph_irq_enable_third_q;
				default: rdata_d = `PIFB_RESET_BYTE;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			ccp_group_irq_flags_q <= `PIFB_RESET_BYTE;
			ccp_group_irq_enable_q <= `PIFB_RESET_BYTE;
			timer_comp_irq_flags_q <= `PIFB_RESET_BYTE;
			timer_comp_irq_enable_q <= `PIFB_RESET_BYTE;
			periph_irq_enable_first_q <= `PIFB_RESET_BYTE;
			periph_irq_enable_second_q <= `PIFB_RESET_BYTE;
			periph_irq_enable_third_q <= `PIFB_RESET_BYTE;
			rdata_q <= `PIFB_RESET_BYTE;
		end else begin
			ccp_group_irq_flags_q <= ccp_group_irq_flags_d;
			ccp_group_irq_enable_q <= ccp_group_irq_enable_d;
			timer_comp_irq_flags_q <= timer_comp_irq_flags_d;
			timer_comp_irq_enable_q <= timer_comp_irq_enable_d;
			periph_irq_enable_first_q <= periph_irq_enable_first_d;
			periph_irq_enable_second_q <= periph_irq_enable_second_d;
			periph_irq_enable_third_q <= periph_irq_enable_third_d;
			rdata_q <= rdata_d;
		end
	end

	assign bus_rdata = rdata_q;

	// Flags of registers 1 to 3 live in their peripherals and only get masked here
	assign periph_irq_pending = |(ccp_group_irq_flags_q & ccp_group_irq_enable_q)
		| |(timer_comp_irq_flags_q & timer_comp_irq_enable_q)
		| |(ext_flags.first & periph_irq_enable_first_q)
		| |(ext_flags.second & periph_irq_enable_second_q)
		| |(ext_flags.third & periph_irq_enable_third_q);
	// With priority levels on, the priority logic downstream does the gating
	assign periph_irq_req = periph_irq_pending & (priority_levels_enable | global_peripheral_irq_enable);

endmodule

// *** src/pifb_params.svh ***
/*
  Constants for the peripheral interrupt flag and enable bank: register
  addresses, field positions and reset values.
  Assumes it is included once per file by its bare name.
*/
`ifndef PIFB_PARAMS_SVH
`define PIFB_PARAMS_SVH

`define PIFB_ADDR_W 12
`define PIFB_DATA_W 8
`define PIFB_OFF_CCP_EN 12'hF8E
`define PIFB_OFF_CCP_FLAG 12'hF8F
`define PIFB_OFF_TC_EN 12'hF91
`define PIFB_OFF_TC_FLAG 12'hF98
`define PIFB_OFF_EN_FIRST 12'hF9D
`define PIFB_OFF_EN_SECOND 12'hFA0
`define PIFB_OFF_EN_THIRD 12'hFA3
`define PIFB_RESET_BYTE 8'h00
`define PIFB_TC_IMPL_MASK 8'h3F
`define PIFB_BIT_CMP3 5
`define PIFB_BIT_PARPORT 7
`define PIFB_TC_W 6

`endif

// *** src/pifb_pkg.sv ***
/*
  Types shared by the peripheral interrupt flag and enable bank.
  Assumes pifb_params.svh is on the include path.
*/
`include "pifb_params.svh"

package pifb_pkg;

	typedef struct packed {
		logic [`PIFB_ADDR_W-1:0] addr;
		logic [`PIFB_DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} pifb_bus_req_t;

	// One strobe per event, all on the system clock
	typedef struct packed {
		logic timer8_period_match;
		logic timer6_period_match;
		logic timer5_overflow;
		logic timer5_gate;
		logic timer1_gate;
	} pifb_tc_events_t;

	typedef struct packed {
		logic [`PIFB_DATA_W-1:0] first;
		logic [`PIFB_DATA_W-1:0] second;
		logic [`PIFB_DATA_W-1:0] third;
	} pifb_ext_flags_t;

endpackage
